// File: hdl/mvf_pkg.sv
// shared constants, encodings and decode helpers of the vlan / address filter command block
package mvf_pkg;

  // ---------------------------------------------------------------------------
  // bus geometry and register offsets
  // ---------------------------------------------------------------------------
  localparam int unsigned APB_AW      = 12;
  localparam int unsigned APB_DW      = 32;
  localparam logic [11:0] ADDR_CMD    = 12'h000;
  localparam logic [11:0] ADDR_PL0    = 12'h004;
  localparam logic [11:0] ADDR_PL1    = 12'h008;
  localparam logic [11:0] ADDR_RESP   = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;

  // ---------------------------------------------------------------------------
  // command and response codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  OP_VLAN_EN       = 8'h0C;
  localparam logic [7:0]  OP_VLAN_DIS      = 8'h0D;
  localparam logic [7:0]  OP_SET_MAC       = 8'h0E;
  localparam logic [7:0]  RSP_FLAG         = 8'h80;
  localparam logic [15:0] RESP_OK          = 16'h0000;
  localparam logic [15:0] RESP_FAIL        = 16'h0001;
  localparam logic [15:0] RESP_UNSUP       = 16'h0002;
  localparam logic [15:0] REASON_NONE      = 16'h0000;
  localparam logic [15:0] REASON_BAD_PARAM = 16'h0002;
  localparam logic [15:0] REASON_ZERO_MAC  = 16'h0008;
  localparam logic [7:0]  RSP_LEN_BYTES    = 8'h2E;   // response incl. checksum and pad

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned CMD_OP_MSB    = 7;
  localparam int unsigned CMD_CKSUM_BIT = 8;
  localparam int unsigned CMD_IDMIS_BIT = 9;
  localparam int unsigned MAC_LO_LSB    = 16;
  localparam int unsigned IDX_LSB       = 8;
  localparam int unsigned KIND_LSB      = 5;
  localparam int unsigned ENA_BIT       = 0;
  localparam logic [2:0]  AK_UNICAST    = 3'h0;
  localparam logic [2:0]  AK_MULTICAST  = 3'h1;
  localparam logic [7:0]  MODE_ONLY     = 8'h01;
  localparam logic [7:0]  MODE_PLUS     = 8'h02;
  localparam logic [7:0]  MODE_ANY      = 8'h03;
  localparam int unsigned MAX_SLOTS     = 8;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    VL_OFF  = 2'b00,
    VL_ONLY = 2'b01,
    VL_PLUS = 2'b10,
    VL_ANY  = 2'b11
  } mvf_vlan_t;

  typedef enum logic [1:0] {
    SK_UC  = 2'b00,
    SK_MC  = 2'b01,
    SK_MIX = 2'b10
  } mvf_kind_t;

  localparam mvf_vlan_t VLAN_RST = VL_OFF;

  // kind of a zero-based slot: unicast slots first, then multicast, then mixed
  function automatic mvf_kind_t slot_kind(input logic [3:0] idx0, input logic [3:0] nuc,
                                          input logic [3:0] nmc);
    if (idx0 < nuc) begin
      return SK_UC;
    end else if (idx0 < 4'(nuc + nmc)) begin
      return SK_MC;
    end
    return SK_MIX;
  endfunction : slot_kind

endpackage : mvf_pkg

// File: hdl/mvf_slot_if.sv
// carrier between the command logic and the address match engine
interface mvf_slot_if;
  logic        wr_en;
  logic [2:0]  wr_idx;
  logic [47:0] wr_addr;
  logic        wr_enable;
  logic [47:0] lk_da;
  logic        hit;
  logic [7:0]  act;

  modport ctl (output wr_en, wr_idx, wr_addr, wr_enable, lk_da, input hit, act);
  modport eng (input wr_en, wr_idx, wr_addr, wr_enable, lk_da, output hit, act);
endinterface : mvf_slot_if

// File: hdl/mvf_match_eng.sv
// exact-match destination address slots
module mvf_match_eng #(
  parameter int unsigned N_SLOTS = 8
) (
  input  wire logic i_clk,
  input  wire logic i_reset,
  mvf_slot_if.eng   slot
);
  import mvf_pkg::*;

  logic [47:0] addr_r   [N_SLOTS];
  logic [47:0] addr_nxt [N_SLOTS];
  logic [N_SLOTS-1:0] act_r;
  logic [N_SLOTS-1:0] act_nxt;
  logic [N_SLOTS-1:0] match;

  // ---------------------------------------------------------------------------
  // slot update: enable loads or overwrites, disable discards the address
  // ---------------------------------------------------------------------------
  always_comb begin
    act_nxt = act_r;
    for (int i = 0; i < N_SLOTS; i++) begin
      addr_nxt[i] = addr_r[i];
    end
    if (slot.wr_en) begin
      act_nxt[slot.wr_idx]  = slot.wr_enable;                              // [RQ10] [RQ12] [RQ14]
      addr_nxt[slot.wr_idx] = slot.wr_enable ? slot.wr_addr : 48'h0000_0000_0000; // [RQ11] [RQ12]
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      act_r <= '0;
      for (int i = 0; i < N_SLOTS; i++) begin
        addr_r[i] <= 48'h0000_0000_0000;
      end
    end else begin
      act_r <= act_nxt;
      for (int i = 0; i < N_SLOTS; i++) begin
        addr_r[i] <= addr_nxt[i];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // full 48-bit compare per slot, only active slots count
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < N_SLOTS; g++) begin : g_cmp
    assign match[g] = act_r[g] && (addr_r[g] == slot.lk_da); // [RQ4] [RQ5]
  end

  assign slot.hit = |match;
  assign slot.act = MAX_SLOTS'(act_r);

endmodule : mvf_match_eng

// File: hdl/mvf_filter_top.sv
// sideband vlan / address filter command interpreter with inbound frame forwarding decision
//
// Notes on behaviour
// RQ1 - enable-vlan command is always answered unless checksum or identifier is bad
// RQ2 - after disable-vlan only untagged frames that hit an address slot pass
// RQ3 - disable-vlan command is always answered unless checksum or identifier is bad
// RQ4 - frames passing vlan check forward when destination equals an active slot address
// RQ5 - slots are unicast, multicast or mixed; mixed matches either kind exactly
// RQ6 - at least one unicast or mixed slot exists
// RQ7 - no more than eight slots in total
// RQ8 - one-based index walks unicast, then multicast, then mixed slots
// RQ9 - unicast address into multicast slot is refused as an error
// RQ10 - enable flag set loads the full address and starts forwarding on it
// RQ11 - enabling an already active slot overwrites its address
// RQ12 - enable flag clear ignores address, clears slot, stops its use
// RQ13 - kind field: zero unicast, one multicast, two to seven reserved
// RQ14 - enable flag: zero disables the slot, one enables it
// RQ15 - eight-bit index, value n selects slot n
// RQ16 - address programming command is always answered unless checksum or identifier bad
// RQ17 - all-zero address answers with the zero-address reason code
// RQ18 - modes: tagged matching only; plus untagged; any frame; address filter always applies
// RQ19 - payload: six address bytes msb first, index byte, kind and enable byte
// RQ20 - response: 16-bit code, 16-bit reason, then checksum and pad
module mvf_filter_top #(
  parameter int unsigned N_UC  = 4,
  parameter int unsigned N_MC  = 2,
  parameter int unsigned N_MIX = 2
) (
  input  wire logic                        I_CLK,
  input  wire logic                        I_RESET,
  input  wire logic                        I_PSEL,
  input  wire logic                        I_PENABLE,
  input  wire logic                        I_PWRITE,
  input  wire logic [mvf_pkg::APB_AW-1:0]  I_PADDR,
  input  wire logic [mvf_pkg::APB_DW-1:0]  I_PWDATA,
  output      logic [mvf_pkg::APB_DW-1:0]  O_PRDATA,
  output      logic                        O_PREADY,
  output      logic                        O_PSLVERR,
  input  wire logic                        I_FRM_VALID,
  input  wire logic [47:0]                 I_FRM_DA,
  input  wire logic                        I_FRM_TAGGED,
  input  wire logic                        I_FRM_VLAN_HIT,
  output      logic                        O_FRM_DONE,
  output      logic                        O_FRM_FWD
);
  import mvf_pkg::*;

  localparam int unsigned N_TOT = N_UC + N_MC + N_MIX;
  localparam logic [3:0]  NUC4  = 4'(N_UC);
  localparam logic [3:0]  NMC4  = 4'(N_MC);
  localparam logic [7:0]  NTOT8 = 8'(N_TOT);

  mvf_slot_if slot ();

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [31:0] prdata_r,  prdata_nxt;
  logic        pready_r,  pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic [31:0] pl0_r,     pl0_nxt;
  logic [31:0] pl1_r,     pl1_nxt;
  logic        rsp_vld_r, rsp_vld_nxt;
  logic [7:0]  rsp_op_r,  rsp_op_nxt;
  logic [15:0] resp_r,    resp_nxt;
  logic [15:0] reason_r,  reason_nxt;
  logic        drop_r,    drop_nxt;
  mvf_vlan_t   vlan_r,    vlan_nxt;
  logic        done_r,    done_nxt;
  logic        fwd_r,     fwd_nxt;

  // ---------------------------------------------------------------------------
  // decode of bus phase and command payload
  // ---------------------------------------------------------------------------
  logic        setup, acc, cmd_wr, cmd_bad, rd_resp, rd_stat, idx_ok, kind_ok, vlan_ok;
  logic [7:0]  op, idx, mode;
  logic [2:0]  akind;
  logic        ena;
  logic [47:0] mac;
  logic [3:0]  idx0;
  mvf_kind_t   skind;

  assign setup   = I_PSEL && !I_PENABLE;
  assign acc     = I_PSEL && I_PENABLE && pready_r;          // transfer completes here
  assign cmd_wr  = acc && I_PWRITE && (I_PADDR == ADDR_CMD);
  assign cmd_bad = I_PWDATA[CMD_CKSUM_BIT] || I_PWDATA[CMD_IDMIS_BIT];
  assign rd_resp = acc && !I_PWRITE && (I_PADDR == ADDR_RESP);
  assign rd_stat = acc && !I_PWRITE && (I_PADDR == ADDR_STATUS);
  assign op      = I_PWDATA[CMD_OP_MSB:0];
  assign mac     = {pl0_r, pl1_r[31:MAC_LO_LSB]};               // [RQ19]
  assign idx     = pl1_r[IDX_LSB+7:IDX_LSB];                     // [RQ15] [RQ19]
  assign akind   = pl1_r[KIND_LSB+2:KIND_LSB];                   // [RQ13] [RQ19]
  assign ena     = pl1_r[ENA_BIT];                               // [RQ14]
  assign mode    = pl0_r[7:0];
  assign idx0    = 4'(idx - 8'h01);
  assign idx_ok  = (idx != 8'h00) && (idx <= NTOT8);             // [RQ8] [RQ15]
  assign skind   = slot_kind(idx0, NUC4, NMC4);                  // [RQ8]
  // reserved kinds never fit; unicast needs a non-multicast slot
  assign kind_ok = ((akind == AK_UNICAST) && (skind != SK_MC))
                || ((akind == AK_MULTICAST) && (skind != SK_UC)); // [RQ9] [RQ13]

  // register read mux, also the mapped-address check
  function automatic logic [32:0] reg_read(input logic [11:0] a, input logic [31:0] p0,
                                           input logic [31:0] p1, input logic [31:0] rsp,
                                           input logic [31:0] st);
    case (a)
      ADDR_CMD:    return {1'b1, 32'h0000_0000};
      ADDR_PL0:    return {1'b1, p0};
      ADDR_PL1:    return {1'b1, p1};
      ADDR_RESP:   return {1'b1, rsp};
      ADDR_STATUS: return {1'b1, st};
      default:     return {1'b0, 32'h0000_0000};
    endcase
  endfunction : reg_read

  // ---------------------------------------------------------------------------
  // apb slave: zero wait states, read data and error prepared in setup
  // ---------------------------------------------------------------------------
  logic [32:0] rd_word;
  logic [31:0] stat_word;

  assign stat_word = {8'h00, RSP_LEN_BYTES, 2'b00, vlan_r, drop_r, rsp_vld_r, 2'b00, rsp_op_r};
  assign rd_word   = reg_read(I_PADDR, pl0_r, pl1_r, {resp_r, reason_r}, stat_word);

  always_comb begin
    pready_nxt  = setup;
    prdata_nxt  = setup ? rd_word[31:0] : 32'h0000_0000;
    pslverr_nxt = setup && !rd_word[32];
    pl0_nxt     = (acc && I_PWRITE && (I_PADDR == ADDR_PL0)) ? I_PWDATA : pl0_r;
    pl1_nxt     = (acc && I_PWRITE && (I_PADDR == ADDR_PL1)) ? I_PWDATA : pl1_r;
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      pl0_r     <= 32'h0000_0000;
      pl1_r     <= 32'h0000_0000;
    end else begin
      pready_r  <= pready_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      pl0_r     <= pl0_nxt;
      pl1_r     <= pl1_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // command execution: one command per write to the command register
  // ---------------------------------------------------------------------------
  always_comb begin
    rsp_vld_nxt    = rsp_vld_r;
    rsp_op_nxt     = rsp_op_r;
    resp_nxt       = resp_r;
    reason_nxt     = reason_r;
    drop_nxt       = drop_r;
    vlan_nxt       = vlan_r;
    slot.wr_en     = 1'b0;
    slot.wr_idx    = idx0[2:0];
    slot.wr_addr   = mac;
    slot.wr_enable = ena;
    // clears first so that a new event in the same cycle wins
    if (rd_resp) begin
      rsp_vld_nxt = 1'b0;
    end
    if (rd_stat) begin
      drop_nxt = 1'b0;
    end
    if (cmd_wr && cmd_bad) begin
      drop_nxt = 1'b1;                                  // damaged command: silently dropped
    end else if (cmd_wr) begin
      rsp_vld_nxt = 1'b1;                               // [RQ1] [RQ3] [RQ16]
      rsp_op_nxt  = op | RSP_FLAG;
      resp_nxt    = RESP_OK;                            // [RQ20]
      reason_nxt  = REASON_NONE;
      case (op)
        OP_VLAN_EN: begin
          case (mode)
            MODE_ONLY: vlan_nxt = VL_ONLY;              // [RQ18]
            MODE_PLUS: vlan_nxt = VL_PLUS;              // [RQ18]
            MODE_ANY:  vlan_nxt = VL_ANY;               // [RQ18]
            default: begin
              resp_nxt   = RESP_FAIL;
              reason_nxt = REASON_BAD_PARAM;
            end
          endcase
        end
        OP_VLAN_DIS: begin
          vlan_nxt = VL_OFF;                            // [RQ2]
        end
        OP_SET_MAC: begin
          if (!idx_ok || (ena && !kind_ok)) begin
            resp_nxt   = RESP_FAIL;                     // [RQ9]
            reason_nxt = REASON_BAD_PARAM;
          end else if (ena && (mac == 48'h0000_0000_0000)) begin
            resp_nxt   = RESP_FAIL;                     // [RQ17]
            reason_nxt = REASON_ZERO_MAC;
          end else begin
            slot.wr_en = 1'b1;                          // [RQ10] [RQ11] [RQ12]
          end
        end
        default: begin
          resp_nxt   = RESP_UNSUP;
          reason_nxt = REASON_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      rsp_vld_r <= 1'b0;
      rsp_op_r  <= 8'h00;
      resp_r    <= RESP_OK;
      reason_r  <= REASON_NONE;
      drop_r    <= 1'b0;
      vlan_r    <= VLAN_RST;
    end else begin
      rsp_vld_r <= rsp_vld_nxt;
      rsp_op_r  <= rsp_op_nxt;
      resp_r    <= resp_nxt;
      reason_r  <= reason_nxt;
      drop_r    <= drop_nxt;
      vlan_r    <= vlan_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // inbound frame decision: vlan gate and address match, one cycle latency
  // ---------------------------------------------------------------------------
  assign slot.lk_da = I_FRM_DA;

  always_comb begin
    case (vlan_r)
      VL_OFF:  vlan_ok = !I_FRM_TAGGED;                        // [RQ2]
      VL_ONLY: vlan_ok = I_FRM_TAGGED && I_FRM_VLAN_HIT;       // [RQ18]
      VL_PLUS: vlan_ok = !I_FRM_TAGGED || I_FRM_VLAN_HIT;      // [RQ18]
      VL_ANY:  vlan_ok = 1'b1;                                 // [RQ18]
      default: vlan_ok = 1'b0;
    endcase
    done_nxt = I_FRM_VALID;
    fwd_nxt  = I_FRM_VALID && vlan_ok && slot.hit;             // [RQ4]
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      done_r <= 1'b0;
      fwd_r  <= 1'b0;
    end else begin
      done_r <= done_nxt;
      fwd_r  <= fwd_nxt;
    end
  end

  // slot storage; width fixed to the count actually built
  mvf_match_eng #(
    .N_SLOTS (N_TOT)
  ) u_eng (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .slot    (slot)
  );

  assign O_PRDATA  = prdata_r;
  assign O_PREADY  = pready_r;
  assign O_PSLVERR = pslverr_r;
  assign O_FRM_DONE = done_r;
  assign O_FRM_FWD  = fwd_r;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_slot_count_max: assert property (@(posedge I_CLK) disable iff (I_RESET) // [RQ7]
    (N_TOT <= MAX_SLOTS)) else $error("too many address slots");
  a_unicast_slot_avail: assert property (@(posedge I_CLK) disable iff (I_RESET) // [RQ6]
    ((N_UC + N_MIX) >= 1)) else $error("no slot can hold a unicast address");
  a_cmd_gets_rsp: assert property (@(posedge I_CLK) disable iff (I_RESET) // [RQ1] [RQ3] [RQ16]
    (cmd_wr && !cmd_bad && !rd_resp) |=> (rsp_vld_r && (rsp_op_r == ($past(op) | RSP_FLAG))))
    else $error("good command without response");
  a_bad_cmd_silent: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (cmd_wr && cmd_bad) |=> ($stable(rsp_op_r) && drop_r && $stable(vlan_r)))
    else $error("damaged command acted upon");
  a_off_blocks_tag: assert property (@(posedge I_CLK) disable iff (I_RESET) // [RQ2]
    (vlan_r == VL_OFF && I_FRM_VALID && I_FRM_TAGGED) |=> (O_FRM_DONE && !O_FRM_FWD))
    else $error("tagged frame passed with vlan disabled");
  a_fwd_needs_hit: assert property (@(posedge I_CLK) disable iff (I_RESET) // [RQ4]
    O_FRM_FWD |-> ($past(I_FRM_VALID) && $past(slot.hit)))
    else $error("frame forwarded without address hit");
  a_any_mode_pass: assert property (@(posedge I_CLK) disable iff (I_RESET) // [RQ18]
    (vlan_r == VL_ANY && I_FRM_VALID && slot.hit) |=> O_FRM_FWD)
    else $error("any-vlan mode dropped a matching frame");
  // a refused zero address must leave the active flag of every slot as it was
  a_zero_mac_reason: assert property (@(posedge I_CLK) disable iff (I_RESET) // [RQ17]
    (cmd_wr && !cmd_bad && op == OP_SET_MAC && idx_ok && ena && kind_ok && mac == 48'h0000_0000_0000)
    |=> ((reason_r == REASON_ZERO_MAC) && $stable(slot.act)))
    else $error("zero address not reported or loaded");
  a_uc_in_mc_fails: assert property (@(posedge I_CLK) disable iff (I_RESET) // [RQ9]
    (cmd_wr && !cmd_bad && op == OP_SET_MAC && ena && akind == AK_UNICAST && idx_ok && skind == SK_MC)
    |-> (!slot.wr_en ##1 (resp_r == RESP_FAIL))) else $error("unicast put into multicast slot");
  a_slot_set_clear: assert property (@(posedge I_CLK) disable iff (I_RESET) // [RQ10] [RQ12]
    slot.wr_en |=> (slot.act[$past(slot.wr_idx)] == $past(slot.wr_enable)))
    else $error("slot active state not updated");

endmodule : mvf_filter_top

// File: sim/mvf_mc_model.sv
// apb master model standing in for the management controller
module mvf_mc_model (
  input  wire logic        i_clk,
  input  wire logic        i_pready,
  output      logic        o_psel,
  output      logic        o_penable,
  output      logic        o_pwrite,
  output      logic [11:0] o_paddr,
  output      logic [31:0] o_pwdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus from time zero, so nothing is requested during reset
  initial begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 12'h000;
    o_pwdata  = 32'h0000_0000;
  end

  // one transfer: setup cycle, then access held until ready is seen
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_psel    <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite  <= wr;
    o_paddr   <= a;
    o_pwdata  <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    // ready is sampled at rising edges only; the bench watchdog bounds a hang, not the model
    do begin
      @(posedge i_clk);
    end while (i_pready !== 1'b1);
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    o_paddr   <= ~a;  // released lines show no stale value
    o_pwdata  <= ~d;
  endtask : xfer
endmodule : mvf_mc_model

// File: sim/mvf_filter_top_bench.sv
// self-checking bench of the vlan and address filter command block
module mvf_filter_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import mvf_pkg::*;

  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        fvalid, ftag, fhit, fdone, ffwd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [47:0] fda, ua, ub, mc, mc2;
  logic [32:0] exp_rd[$];
  logic        exp_fw[$];
  logic [1:0]  cur_mode;
  int          error_cnt, samples_checked;

  mvf_filter_top i_mvf_filter_top (.I_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_FRM_VALID(fvalid), .I_FRM_DA(fda), .I_FRM_TAGGED(ftag),
    .I_FRM_VLAN_HIT(fhit), .O_FRM_DONE(fdone), .O_FRM_FWD(ffwd));
  mvf_mc_model i_mvf_mc_model (.i_clk(clk), .i_pready(pready), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));

  // ---------------------------------------------------------------------------
  // clock, verdict and checking
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic stop_test();
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // outputs stand one cycle, so sampling at the edge that ends it sees each exactly once
  always @(posedge clk) begin
    if (pready === 1'b1 && pwrite === 1'b0) check({pslverr, prdata}, exp_rd.size() ? exp_rd.pop_front() : 'x);
    if (fdone === 1'b1) check({32'h0000_0000, ffwd}, {32'h0000_0000, exp_fw.size() ? exp_fw.pop_front() : 1'bx});
  end

  // hang guard, well above the roughly 570 cycles the run needs
  initial begin
    #(25 * 20000);
    error_cnt++;
    stop_test();
  end

  // ---------------------------------------------------------------------------
  // stimulus helpers
  // ---------------------------------------------------------------------------
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_rd.push_back(e);
    i_mvf_mc_model.xfer(1'b0, a, 32'h0000_0000);
  endtask : rd

  function automatic logic [32:0] stat(input logic [7:0] op, input logic v, input logic d);
    return {9'h000, RSP_LEN_BYTES, 2'b00, cur_mode, d, v, 2'b00, op};
  endfunction : stat

  // payload, then the command word; status and response are read back in that order
  task automatic cmd(input logic [7:0] op, input logic [31:0] p0, input logic [31:0] p1,
                     input logic [15:0] code, input logic [15:0] rsn);
    i_mvf_mc_model.xfer(1'b1, ADDR_PL0, p0);
    i_mvf_mc_model.xfer(1'b1, ADDR_PL1, p1);
    i_mvf_mc_model.xfer(1'b1, ADDR_CMD, {24'h00_0000, op});
    if (op == OP_VLAN_DIS) cur_mode = 2'h0;
    else if (op == OP_VLAN_EN && code == RESP_OK) cur_mode = p0[1:0];
    rd(ADDR_STATUS, stat(op | RSP_FLAG, 1'b1, 1'b0));
    rd(ADDR_RESP, {1'h0, code, rsn});
  endtask : cmd

  task automatic mac(input logic [47:0] a, input logic [7:0] idx, input logic [2:0] k, input logic en,
                     input logic [15:0] code, input logic [15:0] rsn);
    cmd(OP_SET_MAC, a[47:16], {a[15:0], idx, k, 4'h0, en}, code, rsn);
  endtask : mac

  task automatic frm(input logic [47:0] da, input logic tg, input logic hit, input logic e);
    exp_fw.push_back(e);
    @(posedge clk);
    fvalid <= 1'b1;
    fda    <= da;
    ftag   <= tg;
    fhit   <= hit;
    @(posedge clk);
    fvalid <= 1'b0;
  endtask : frm

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    rst = 1'b1;
    fvalid = 1'b0;
    fda = 48'h0000_0000_0000;
    ftag = 1'b0;
    fhit = 1'b0;
    cur_mode = 2'h0;
    void'($urandom(67059));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_STATUS, stat(8'h00, 1'b0, 1'b0));
    rd(12'h020, 33'h1_0000_0000);
    i_mvf_mc_model.xfer(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
    for (int m = 0; m < 5; m++) begin
      cmd(OP_VLAN_EN, 32'(m), 32'h0000_0000, (m inside {[1:3]}) ? RESP_OK : RESP_FAIL,
          (m inside {[1:3]}) ? REASON_NONE : REASON_BAD_PARAM);
    end
    // a bad checksum or identifier drops the command without an answer
    for (int b = 8; b < 10; b++) begin
      i_mvf_mc_model.xfer(1'b1, ADDR_CMD, {22'h00_0000, b == 9, b == 8, OP_VLAN_DIS});
      rd(ADDR_STATUS, stat(OP_VLAN_EN | RSP_FLAG, 1'b0, 1'b1));
      rd(ADDR_STATUS, stat(OP_VLAN_EN | RSP_FLAG, 1'b0, 1'b0));
    end
    cmd(OP_VLAN_DIS, 32'h0000_0000, 32'h0000_0000, RESP_OK, REASON_NONE);
    cmd(8'h55, 32'h0000_0000, 32'h0000_0000, RESP_UNSUP, REASON_NONE);
    ua = 48'({$urandom, $urandom});
    ua[41:40] = 2'b10;
    ub = 48'({$urandom, $urandom});
    ub[42:40] = {~ua[42], 2'b10};
    mc = ua | 48'h0100_0000_0000;
    mc2 = ub | 48'h0100_0000_0000;
    mac(ua, 8'h01, AK_UNICAST, 1'b1, RESP_OK, REASON_NONE);
    frm(ua, 1'b0, 1'b0, 1'b1);
    frm(ua ^ 48'h0000_0000_0001, 1'b0, 1'b0, 1'b0);
    frm(ua, 1'b1, 1'b1, 1'b0);
    mac(ub, 8'h01, AK_UNICAST, 1'b1, RESP_OK, REASON_NONE);
    frm(ua, 1'b0, 1'b0, 1'b0);
    frm(ub, 1'b0, 1'b0, 1'b1);
    mac(48'h0000_0000_0000, 8'h01, AK_UNICAST, 1'b0, RESP_OK, REASON_NONE);
    frm(ub, 1'b0, 1'b0, 1'b0);
    mac(48'h0000_0000_0000, 8'h02, AK_UNICAST, 1'b1, RESP_FAIL, REASON_ZERO_MAC);
    mac(ua, 8'h05, AK_UNICAST, 1'b1, RESP_FAIL, REASON_BAD_PARAM);
    mac(mc, 8'h04, AK_MULTICAST, 1'b1, RESP_FAIL, REASON_BAD_PARAM);
    for (int k = 2; k < 8; k++) mac(ua, 8'h02, 3'(k), 1'b1, RESP_FAIL, REASON_BAD_PARAM);
    mac(ua, 8'h00, AK_UNICAST, 1'b1, RESP_FAIL, REASON_BAD_PARAM);
    mac(ua, 8'h09, AK_UNICAST, 1'b1, RESP_FAIL, REASON_BAD_PARAM);
    mac(mc, 8'h05, AK_MULTICAST, 1'b1, RESP_OK, REASON_NONE);
    mac(ua, 8'h07, AK_UNICAST, 1'b1, RESP_OK, REASON_NONE);
    mac(mc2, 8'h08, AK_MULTICAST, 1'b1, RESP_OK, REASON_NONE);
    mac(ub, 8'h04, AK_UNICAST, 1'b1, RESP_OK, REASON_NONE);
    frm(mc, 1'b0, 1'b0, 1'b1);
    frm(mc2, 1'b0, 1'b0, 1'b1);
    frm(ub, 1'b0, 1'b0, 1'b1);
    // every vlan mode against every tag and vlan-hit combination
    for (int m = 0; m < 4; m++) begin
      if (m == 0) cmd(OP_VLAN_DIS, 32'h0000_0000, 32'h0000_0000, RESP_OK, REASON_NONE);
      else cmd(OP_VLAN_EN, 32'(m), 32'h0000_0000, RESP_OK, REASON_NONE);
      for (int t = 0; t < 4; t++) begin
        frm(ua, t[1], t[0], m == 0 ? !t[1] : m == 1 ? t[1] && t[0] : m == 2 ? !t[1] || t[0] : 1'b1);
        frm(48'({$urandom, $urandom}), t[1], t[0], 1'b0);
      end
    end
    repeat (4) @(posedge clk);
    if (exp_rd.size() + exp_fw.size() != 0) error_cnt++;
    stop_test();
  end
endmodule : mvf_filter_top_bench
